// ---- rtl/wwdt_pkg.sv ----
// constants shared by the windowed watchdog core and its period counter
// assumes a byte-wide cpu data path with 16-bit addresses
package wwdt_pkg;
  // restart register location and values
  localparam logic [15:0] KEY_ADDR = 16'hFF99;
  localparam logic [7:0] RESTART_KEY = 8'hAC;
  localparam logic [7:0] KEY_READ_ON = 8'h9A;
  localparam logic [7:0] KEY_READ_OFF = 8'h1A;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  // data accesses at or above this address are never flagged by the area check
  localparam logic [15:0] DATA_FREE_LO = 16'hFB00;
  // option byte field positions
  localparam int OPT_WIN_LSB = 5;
  localparam int OPT_EN_BIT = 4;
  localparam int OPT_OVF_LSB = 1;
  // reset cause register bit for a watchdog reset
  localparam int CAUSE_WDT_BIT = 4;
  localparam logic [7:0] CAUSE_WDT_MASK = 8'h10;
  // overflow period is 2**(OVF_BASE_EXP + select) low-speed cycles
  localparam int OVF_BASE_EXP = 10;
  localparam int CNT_W = 17;
  // control states of the core
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_FIRED} wwdt_state_t;
endpackage

// ---- rtl/wwdt_counter.sv ----
// period counter of the windowed watchdog: counts low-speed ticks, flags
// overflow and tells whether the restart window is open
// assumes i_tick is a one-cycle pulse per low-speed oscillator edge
`timescale 1ns/1ps
module wwdt_counter #(
  parameter int CNT_W = wwdt_pkg::CNT_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [2:0] i_ovf_sel,
  input wire logic [1:0] i_win_sel,
  // status
  output logic o_overflow,
  output logic o_open,
  output logic [CNT_W-1:0] o_count
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
  } wwdt_cnt_st_t;

  wwdt_cnt_st_t s_r;
  wwdt_cnt_st_t s_nxt;
  logic [CNT_W:0] period;
  logic [CNT_W:0] quarter;
  logic [CNT_W:0] open_start;

  // the longest select code needs all CNT_W bits
  if (CNT_W < wwdt_pkg::OVF_BASE_EXP + 7) begin : g_chk
    $error("wwdt_counter: CNT_W too small for the longest overflow period");
  end

  // period and window start; closed first, open last up to overflow
  always_comb begin
    period = (CNT_W+1)'(1) << (wwdt_pkg::OVF_BASE_EXP + int'(i_ovf_sel));
    quarter = period >> 2;
    open_start = period - quarter * (CNT_W+1)'({1'b0, i_win_sel} + 3'd1);
    o_open = {1'b0, s_r.count} >= open_start;
    o_overflow = i_run && i_tick && !i_clear
                 && ({1'b0, s_r.count} == period - (CNT_W+1)'(1));
    o_count = s_r.count;
  end

  // next count; a clear wins over a tick so a late restart still saves the cpu
  always_comb begin
    s_nxt = s_r;
    if (i_clear) begin
      s_nxt.count = '0;
    end else if (i_run && i_tick) begin
      s_nxt.count = o_overflow ? '0 : s_r.count + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // an overflow tick starts the next period from zero
  overflow_last_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overflow |=> o_count == '0)
    else $error("count did not wrap after overflow");
  // the count never reaches the period length, whatever the select code
  count_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    {1'b0, o_count} < period)
    else $error("count ran past the period end");
  // the window is closed right after a restart, except with window select 2'b11, which is always open
  closed_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clear |=> !o_open || (i_win_sel == 2'b11))
    else $error("window open at the start of a period");
endmodule // wwdt_counter

// ---- rtl/wwdt_core.sv ----
// windowed watchdog core: restart register, violation checks, reset request
// assumes the cpu presents one access per cycle and the option byte is
// stable at reset release; low-speed clock edges arrive as I_LS_TICK pulses
`timescale 1ns/1ps
module wwdt_core #(
  parameter int CNT_W = wwdt_pkg::CNT_W
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // low-speed oscillator edge and option byte
  input wire logic I_LS_TICK,
  input wire logic [7:0] I_OPTION_BYTE,
  // memory area configuration
  input wire logic [15:0] I_ROM_END,
  input wire logic [15:0] I_RAM_START,
  // cpu data access
  input wire logic I_RD_EN,
  input wire logic I_WR_EN,
  input wire logic I_BIT_OP,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  // cpu instruction fetch
  input wire logic I_FETCH_EN,
  input wire logic [15:0] I_FETCH_ADDR,
  // reset cause and request
  input wire logic I_CAUSE_CLR,
  output logic [7:0] O_RESET_CAUSE,
  output logic O_RESET_REQ
);
  typedef struct packed {
    wwdt_pkg::wwdt_state_t state;
    logic en;
    logic [1:0] win;
    logic [2:0] ovf;
    logic [7:0] key_read;
    logic first_done;
    logic pend;
    logic cause;
    logic [7:0] rdata;
  } wwdt_st_t;

  wwdt_st_t s_r;
  wwdt_st_t s_nxt;
  logic wr_key;
  logic armed;
  logic clr_now;
  logic viol;
  logic fire;
  logic ovf_hit;
  logic win_open;
  logic [CNT_W-1:0] count;

  // an address inside either configured area is legal
  function automatic logic in_area(input logic [15:0] a, input logic [15:0] rom_end,
                                   input logic [15:0] ram_start);
    in_area = (a < rom_end) || (a >= ram_start);
  endfunction

  // restart register decode and violation checks, live only while enabled
  always_comb begin
    wr_key = I_WR_EN && (I_ADDR == wwdt_pkg::KEY_ADDR);
    armed = (s_r.state == wwdt_pkg::ST_RUN) && s_r.en;
    clr_now = 1'b0;
    viol = 1'b0;
    if (armed) begin
      if (wr_key) begin
        if (I_BIT_OP) begin
          viol = 1'b1;
        end else if (I_WDATA != wwdt_pkg::RESTART_KEY) begin
          viol = 1'b1;
        end else if (!win_open && s_r.first_done) begin
          viol = 1'b1;
        end else begin
          clr_now = 1'b1;
        end
      end
      if (I_FETCH_EN && !in_area(I_FETCH_ADDR, I_ROM_END, I_RAM_START)) begin
        viol = 1'b1;
      end
      if ((I_RD_EN || I_WR_EN) && (I_ADDR < wwdt_pkg::DATA_FREE_LO)
          && !in_area(I_ADDR, I_ROM_END, I_RAM_START)) begin
        viol = 1'b1;
      end
      if (ovf_hit) begin
        viol = 1'b1;
      end
    end
    // pending violations wait for the low-speed clock, as a stopped source would
    fire = armed && s_r.pend && I_LS_TICK;
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      wwdt_pkg::ST_LOAD: begin
        // option byte is caught one edge after release, never under reset
        s_nxt.en = I_OPTION_BYTE[wwdt_pkg::OPT_EN_BIT];
        s_nxt.win = I_OPTION_BYTE[wwdt_pkg::OPT_WIN_LSB +: 2];
        s_nxt.ovf = I_OPTION_BYTE[wwdt_pkg::OPT_OVF_LSB +: 3];
        s_nxt.key_read = I_OPTION_BYTE[wwdt_pkg::OPT_EN_BIT] ? wwdt_pkg::KEY_READ_ON
                                                            : wwdt_pkg::KEY_READ_OFF;
        s_nxt.state = wwdt_pkg::ST_RUN;
      end
      wwdt_pkg::ST_RUN: begin
        if (clr_now) begin
          s_nxt.first_done = 1'b1;
        end
        s_nxt.pend = s_r.pend || viol;
        if (fire) begin
          s_nxt.state = wwdt_pkg::ST_FIRED;
        end
      end
      wwdt_pkg::ST_FIRED: begin
        s_nxt.state = wwdt_pkg::ST_FIRED; // held until the system reset arrives
      end
      default: begin
        s_nxt.state = wwdt_pkg::ST_LOAD;
      end
    endcase
    // cause flag: a new watchdog reset beats a clear in the same cycle
    if (fire) begin
      s_nxt.cause = 1'b1;
    end else if (I_CAUSE_CLR) begin
      s_nxt.cause = 1'b0;
    end
    // the written key is not readable; software only sees KEY_READ_ON or KEY_READ_OFF, picked by the enable bit
    s_nxt.rdata = (I_RD_EN && (I_ADDR == wwdt_pkg::KEY_ADDR)) ? s_r.key_read
                                                             : wwdt_pkg::RDATA_IDLE;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_r <= '{state: wwdt_pkg::ST_LOAD, en: 1'b0, win: 2'b00, ovf: 3'b000,
               key_read: wwdt_pkg::KEY_READ_ON, first_done: 1'b0, pend: 1'b0,
               cause: 1'b0, rdata: wwdt_pkg::RDATA_IDLE};
    end else begin
      s_r <= s_nxt;
    end
  end

  // period counter on low-speed ticks
  wwdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_tick(I_LS_TICK),
    .i_run(armed),
    .i_clear(clr_now),
    .i_ovf_sel(s_r.ovf),
    .i_win_sel(s_r.win),
    .o_overflow(ovf_hit),
    .o_open(win_open),
    .o_count(count)
  );

  // outputs straight from flip-flops
  assign O_RDATA = s_r.rdata;
  assign O_RESET_REQ = (s_r.state == wwdt_pkg::ST_FIRED);
  assign O_RESET_CAUSE = s_r.cause ? wwdt_pkg::CAUSE_WDT_MASK : 8'h00;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  pend_fires_a: assert property (s_r.pend && armed && I_LS_TICK |=> O_RESET_REQ)
    else $error("pending violation did not fire on tick");
  no_tick_hold_a: assert property (s_r.pend && armed && !I_LS_TICK |=> !O_RESET_REQ)
    else $error("reset fired without a low-speed tick");
  bit_op_a: assert property (armed && wr_key && I_BIT_OP |=> s_r.pend)
    else $error("bit write to restart register not flagged");
  bad_key_a: assert property (armed && wr_key && !I_BIT_OP
                              && I_WDATA != wwdt_pkg::RESTART_KEY |=> s_r.pend)
    else $error("wrong key not flagged");
  closed_write_a: assert property (armed && wr_key && !I_BIT_OP && !win_open
                                   && s_r.first_done |=> s_r.pend)
    else $error("closed window write not flagged");
  first_restart_a: assert property (armed && !s_r.pend && !s_r.first_done && wr_key
                                    && !I_BIT_OP && I_WDATA == wwdt_pkg::RESTART_KEY
                                    && !I_FETCH_EN && I_ADDR >= wwdt_pkg::DATA_FREE_LO
                                    |=> count == '0 && !s_r.pend)
    else $error("first restart did not clear the counter");
  fetch_bad_a: assert property (armed && I_FETCH_EN
                                && !in_area(I_FETCH_ADDR, I_ROM_END, I_RAM_START)
                                |=> s_r.pend)
    else $error("illegal fetch not flagged");
  data_bad_a: assert property (armed && I_RD_EN && I_ADDR < wwdt_pkg::DATA_FREE_LO
                               && !in_area(I_ADDR, I_ROM_END, I_RAM_START) |=> s_r.pend)
    else $error("illegal data access not flagged");
  overflow_req_a: assert property (armed && ovf_hit |=> s_r.pend)
    else $error("overflow not flagged");
  cause_set_a: assert property ($rose(O_RESET_REQ)
    |-> O_RESET_CAUSE[wwdt_pkg::CAUSE_WDT_BIT])
    else $error("cause flag missing on watchdog reset");
  read_value_a: assert property (s_r.state != wwdt_pkg::ST_LOAD && I_RD_EN
                                 && I_ADDR == wwdt_pkg::KEY_ADDR
                                 |=> O_RDATA == (s_r.en ? wwdt_pkg::KEY_READ_ON
                                                        : wwdt_pkg::KEY_READ_OFF))
    else $error("restart register read value wrong");
  disabled_quiet_a: assert property (s_r.state == wwdt_pkg::ST_RUN && !s_r.en
                                     |=> !s_r.pend && $stable(count))
    else $error("disabled watchdog counted or flagged");
endmodule // wwdt_core

// ---- testbench/wwdt_cpu_model.sv ----
// cpu core model: one-cycle data reads, byte writes, bit writes and fetches
// assumes the watchdog samples its cpu inputs on the rising edge of i_clk
`timescale 1ns/1ps
module wwdt_cpu_model (
  // clock
  input wire logic i_clk,
  // cpu access outputs
  output logic o_rd_en,
  output logic o_wr_en,
  output logic o_bit_op,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_fetch_en,
  output logic [15:0] o_fetch_addr
);
  // idle bus at time zero
  initial begin
    {o_rd_en, o_wr_en, o_bit_op, o_fetch_en} = 4'h0;
    o_addr = 16'h0000;
    o_wdata = 8'h00;
    o_fetch_addr = 16'h0000;
  end

  // kind 0 read, 1 byte write, 2 bit write, 3 fetch; driven on the falling edge
  task automatic access(input logic [1:0] kind, input logic [15:0] addr,
                        input logic [7:0] data);
    @(negedge i_clk);
    o_rd_en = (kind == 2'h0);
    o_wr_en = (kind == 2'h1) || (kind == 2'h2);
    o_bit_op = (kind == 2'h2); // bit writes only when a test asks
    o_wdata = data; // every write carries a whole byte
    o_addr = addr;
    o_fetch_addr = addr;
    o_fetch_en = (kind == 2'h3);
    @(negedge i_clk);
    {o_rd_en, o_wr_en, o_bit_op, o_fetch_en} = 4'h0;
    // released lines flip so a stale value cannot pass for a live one
    o_addr = ~addr;
    o_wdata = ~data;
    o_fetch_addr = ~addr;
  endtask
endmodule // wwdt_cpu_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the windowed watchdog core
// assumes a 20 MHz core clock and a low-speed tick on every core cycle outside the stopped clock test
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] opt;
    logic [1:0] kind;
    logic [15:0] addr;
    logic [7:0] data;
    logic req;
    logic [7:0] rd;
  } wwdt_row_t;
  // option byte, access, address, data, reset expected, read data expected
  localparam wwdt_row_t ROWS [11] = '{
    '{8'h70, 2'h0, 16'hFF99, 8'h00, 1'b0, 8'h9A},
    '{8'h60, 2'h0, 16'hFF99, 8'h00, 1'b0, 8'h1A},
    '{8'h60, 2'h1, 16'hFF99, 8'h00, 1'b0, 8'h00},
    '{8'h70, 2'h1, 16'hFF99, 8'hAC, 1'b0, 8'h00},
    '{8'h70, 2'h1, 16'hFF99, 8'h00, 1'b1, 8'h00},
    '{8'h70, 2'h2, 16'hFF99, 8'hAC, 1'b1, 8'h00},
    '{8'h70, 2'h3, 16'h8000, 8'h00, 1'b1, 8'h00},
    '{8'h70, 2'h0, 16'h8000, 8'h00, 1'b1, 8'h00},
    '{8'h70, 2'h1, 16'hFB00, 8'h55, 1'b0, 8'h00},
    '{8'h70, 2'h3, 16'hFB00, 8'h00, 1'b1, 8'h00},
    '{8'h60, 2'h3, 16'h8000, 8'h00, 1'b0, 8'h00}
  };
  logic clk, rst, tick, cause_clr, req, rd_en, wr_en, bit_op, fetch_en;
  logic [7:0] opt, rdata, cause, wdata;
  logic [15:0] addr, fetch_addr, rom_end, ram_start;
  int failures = 0;
  int n_tests = 0;
  int n;

  wwdt_cpu_model cpu (.i_clk(clk), .o_rd_en(rd_en), .o_wr_en(wr_en), .o_bit_op(bit_op),
    .o_addr(addr), .o_wdata(wdata), .o_fetch_en(fetch_en), .o_fetch_addr(fetch_addr));
  // rom below 4000, ram from fc00 by default: fb00 lies outside yet is exempt for data
  wwdt_core DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_LS_TICK(tick), .I_OPTION_BYTE(opt),
    .I_ROM_END(rom_end), .I_RAM_START(ram_start), .I_RD_EN(rd_en), .I_WR_EN(wr_en),
    .I_BIT_OP(bit_op), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
    .I_FETCH_EN(fetch_en), .I_FETCH_ADDR(fetch_addr), .I_CAUSE_CLR(cause_clr),
    .O_RESET_CAUSE(cause), .O_RESET_REQ(req));

  // 50 ns core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // reset for three cycles, then let the option byte load
  task automatic start(input logic [7:0] o);
    opt = o;
    tick = 1'b1;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask

  // bounded wait for the reset request; running out ends the run
  task automatic wait_req(input int bound, output int cnt);
    cnt = 0;
    while (req !== 1'b1) begin
      if (cnt == bound) begin
        failures++;
        close_out();
      end
      @(negedge clk);
      cnt++;
    end
  endtask

  initial begin
    cause_clr = 1'b0;
    rom_end = 16'h4000;
    ram_start = 16'hFC00;
    start(8'h70);
    chk(cause, 8'h00);
    foreach (ROWS[i]) begin
      start(ROWS[i].opt);
      cpu.access(ROWS[i].kind, ROWS[i].addr, ROWS[i].data);
      chk(rdata, ROWS[i].rd);
      repeat (3) @(negedge clk);
      chk({7'h0, req}, {7'h0, ROWS[i].req});
      chk(cause, ROWS[i].req ? 8'h10 : 8'h00);
      $display("row %0d done", i);
    end
    // overflow without restart, for two period codes
    for (int s = 0; s < 2; s++) begin
      start(8'h70 + 8'(2 * s));
      wait_req(1024 * 2 ** s + 20, n);
      chk({7'h0, n >= 1024 * 2 ** s - 2}, 8'h01);
      chk({7'h0, n <= 1024 * 2 ** s + 4}, 8'h01);
    end
    $display("overflow test done");
    // 25 percent window of a 2048 period: open from count 1536
    start(8'h12);
    cpu.access(2'h1, 16'hFF99, 8'hAC);
    repeat (3) @(negedge clk);
    chk({7'h0, req}, 8'h00);
    repeat (1600) @(negedge clk);
    cpu.access(2'h1, 16'hFF99, 8'hAC);
    repeat (3) @(negedge clk);
    chk({7'h0, req}, 8'h00);
    cpu.access(2'h1, 16'hFF99, 8'hAC);
    wait_req(4, n);
    chk(cause, 8'h10);
    // clearing the cause leaves the request standing until reset
    cause_clr = 1'b1;
    @(negedge clk);
    cause_clr = 1'b0;
    @(negedge clk);
    chk(cause, 8'h00);
    chk({7'h0, req}, 8'h01);
    $display("window test done");
    // stopped low-speed clock holds a bad key pending
    start(8'h70);
    tick = 1'b0;
    cpu.access(2'h1, 16'hFF99, 8'h5A);
    repeat (20) @(negedge clk);
    chk({7'h0, req}, 8'h00);
    tick = 1'b1;
    wait_req(4, n);
    chk(cause, 8'h10);
    $display("stopped clock test done");
    // 50 and 75 percent windows of a 1024 period open at counts 512 and 256
    for (int w = 1; w < 3; w++) begin
      start(8'h10 + 8'(32 * w));
      cpu.access(2'h1, 16'hFF99, 8'hAC);
      repeat (1024 - 256 * (w + 1) + 4) @(negedge clk);
      cpu.access(2'h1, 16'hFF99, 8'hAC);
      repeat (3) @(negedge clk);
      chk({7'h0, req}, 8'h00);
      repeat (1024 - 256 * (w + 1) - 12) @(negedge clk);
      cpu.access(2'h1, 16'hFF99, 8'hAC);
      repeat (3) @(negedge clk);
      chk({7'h0, req}, 8'h01);
      $display("window %0d test done", w);
    end
    // a larger rom area makes the same fetch and read legal
    rom_end = 16'h9000;
    start(8'h70);
    cpu.access(2'h3, 16'h8000, 8'h00);
    cpu.access(2'h0, 16'h8000, 8'h00);
    repeat (3) @(negedge clk);
    chk({7'h0, req}, 8'h00);
    cpu.access(2'h0, 16'h9000, 8'h00);
    repeat (3) @(negedge clk);
    chk({7'h0, req}, 8'h01);
    rom_end = 16'h4000;
    $display("area config test done");
    close_out();
  end
endmodule // tb_top
